// ==== inc/wdog_pkg.sv ====
/*
  constants for the dual watchdog block: i/o port addresses, legacy index
  values, field positions, reset values and time base figures.
  assumes a host i/o bus with 16-bit port address and byte data.
*/
package wdog_pkg;
  // =========================================================
  // i/o ports
  localparam logic [15:0] PORT_INDEX = 16'h0022;
  localparam logic [15:0] PORT_DATA = 16'h0023;
  localparam logic [15:0] PORT_SEC_RELOAD = 16'h0067;
  localparam logic [15:0] PORT_SEC_CTRL = 16'h0068;
  localparam logic [15:0] PORT_SEC_ACT = 16'h0069;
  localparam logic [15:0] PORT_SEC_CNT_LO = 16'h006A;
  localparam logic [15:0] PORT_SEC_CNT_MID = 16'h006B;
  localparam logic [15:0] PORT_SEC_CNT_HI = 16'h006C;
  localparam logic [15:0] PORT_SEC_STATUS = 16'h006D;
  // =========================================================
  // legacy indexes
  localparam logic [7:0] IDX_LOCK = 8'h13;
  localparam logic [7:0] IDX_ENABLE = 8'h37;
  localparam logic [7:0] IDX_ACT = 8'h38;
  localparam logic [7:0] IDX_CNT_LO = 8'h39;
  localparam logic [7:0] IDX_CNT_MID = 8'h3A;
  localparam logic [7:0] IDX_CNT_HI = 8'h3B;
  localparam logic [7:0] IDX_STATUS = 8'h3C;
  localparam logic [7:0] UNLOCK_KEY = 8'hC5;
  // =========================================================
  // fields
  localparam int BIT_ENABLE = 6;
  localparam int BIT_KICK = 6;
  localparam int BIT_FIRED = 7;
  localparam int ACT_LSB = 4;
  localparam int CNT_W = 24;
  localparam logic [7:0] ENABLE_MASK = 8'h40;
  localparam logic [7:0] ACT_MASK = 8'hF0;
  localparam logic [7:0] LEGACY_EN_RESET = 8'h40;
  localparam logic [7:0] SEC_EN_RESET = 8'h00;
  localparam logic [7:0] READ_UNDEF = 8'hFF;
  // =========================================================
  // action codes
  localparam logic [3:0] ACT_NMI = 4'hC;
  localparam logic [3:0] ACT_SYSRST = 4'hD;
  // =========================================================
  // time base
  localparam int CLK_HZ = 40000000;
  localparam int TICK_HZ = 32768;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
endpackage : wdog_pkg

// ==== inc/wdog_tmr_if.sv ====
/*
  interface between the register front end and one timer core.
  assumes both ends share i_clk.
*/
`timescale 1ns/1ps
interface wdog_tmr_if;
  logic enable;
  logic restart;
  logic tick;
  logic [23:0] limit;
  logic [23:0] count;
  logic expire;
  modport regs (output enable, output restart, output tick, output limit,
    input count, input expire);
  modport core (input enable, input restart, input tick, input limit,
    output count, output expire);
endinterface : wdog_tmr_if

// ==== verilog/wdog_core.sv ====
/*
  one 24-bit up-counting watchdog core.
  assumes a one-cycle tick from the 32.768 khz time base.
*/
`timescale 1ns/1ps
module wdog_core (
  input wire logic i_clk,
  input wire logic i_rst,
  wdog_tmr_if.core tmr
);
  import wdog_pkg::*;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic expire_q;
  logic hit;
  // =========================================================
  // counter
  assign hit = tmr.enable && tmr.tick && (count_q + 24'h000001 == tmr.limit);
  always_comb begin
    count_d = count_q;
    if (!tmr.enable || tmr.restart) begin
      count_d = '0;
    end else if (tmr.tick && !expire_q) begin
      count_d = count_q + 24'h000001;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_q <= '0;
      expire_q <= 1'b0;
    end else begin
      count_q <= count_d;
      // hold at the limit until restart so the event is a single pulse
      expire_q <= tmr.enable && !tmr.restart && (expire_q || hit);
    end
  end
  assign tmr.count = count_q;
  assign tmr.expire = hit && !expire_q && !tmr.restart;
endmodule : wdog_core

// ==== verilog/dual_watchdog_timer.sv ====
/*
  two independent watchdog timers behind host i/o port cycles: a legacy
  one behind an index/data port pair and a second with direct ports.
  assumes one-cycle read/write strobes on i_clk from the host bus.
*/
// What this block does
// - legacy registers via index then data port
// - legacy counts 24 bits at 32.768 khz
// - timeout from one tick to 512 s
// - legacy timeout bytes at 3Bh 3Ah 39h
// - enable bit starts count from zero
// - clearing enable stops and zeroes counter
// - count equal timeout fires selected action
// - action code decodes irq, nmi, reset
// - legacy fired flag is read-only
// - writing kick bit restarts legacy count
// - second timer decoded on direct ports
// - second control bit 6 enables counter
// - second timeout bytes at 6Ah to 6Ch
// - second fired flag, write one clears
// - any reload write restarts second counter
// - both timers run fully independent
`timescale 1ns/1ps
module dual_watchdog_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  output logic o_io_hit,
  output logic [15:0] o_irq,
  output logic o_nmi,
  output logic o_sys_reset
);
  import wdog_pkg::*;

  // =========================================================
  // action decode
  function automatic logic [17:0] act_decode(input logic [3:0] code);
    logic [17:0] v;
    v = '0;
    case (code)
      4'h1: v[3] = 1'b1;
      4'h2: v[4] = 1'b1;
      4'h3: v[5] = 1'b1;
      4'h4: v[6] = 1'b1;
      4'h5: v[7] = 1'b1;
      4'h6: v[9] = 1'b1;
      4'h7: v[10] = 1'b1;
      4'h9: v[12] = 1'b1;
      4'hA: v[14] = 1'b1;
      4'hB: v[15] = 1'b1;
      ACT_NMI: v[16] = 1'b1;
      ACT_SYSRST: v[17] = 1'b1;
      default: v = '0;
    endcase
    return v;
  endfunction : act_decode

  // =========================================================
  // time base
  logic [15:0] div_q;
  logic tick;
  assign tick = (div_q == 16'(TICK_DIV - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // =========================================================
  // port decode
  logic wr_index, wr_data, rd_data;
  logic sec_wr_reload, sec_wr_ctrl, sec_wr_act, sec_wr_status;
  logic sec_wr_lo, sec_wr_mid, sec_wr_hi;
  logic port_sec;
  assign wr_index = i_io_wr && (i_io_addr == PORT_INDEX);
  assign wr_data = i_io_wr && (i_io_addr == PORT_DATA);
  assign rd_data = i_io_rd && (i_io_addr == PORT_DATA);
  assign sec_wr_reload = i_io_wr && (i_io_addr == PORT_SEC_RELOAD);
  assign sec_wr_ctrl = i_io_wr && (i_io_addr == PORT_SEC_CTRL);
  assign sec_wr_act = i_io_wr && (i_io_addr == PORT_SEC_ACT);
  assign sec_wr_lo = i_io_wr && (i_io_addr == PORT_SEC_CNT_LO);
  assign sec_wr_mid = i_io_wr && (i_io_addr == PORT_SEC_CNT_MID);
  assign sec_wr_hi = i_io_wr && (i_io_addr == PORT_SEC_CNT_HI);
  assign sec_wr_status = i_io_wr && (i_io_addr == PORT_SEC_STATUS);
  assign port_sec = (i_io_addr >= PORT_SEC_RELOAD) &&
    (i_io_addr <= PORT_SEC_STATUS);

  // =========================================================
  // legacy registers
  logic [7:0] index_q;
  logic unlock_q;
  logic [7:0] leg_en_q, leg_act_q, leg_lo_q, leg_mid_q, leg_hi_q;
  logic leg_fired_q;
  logic leg_kick;
  logic leg_wr_cfg;
  // unlock gates the config and kick writes; reads stay open for polling
  assign leg_wr_cfg = wr_data && unlock_q;
  assign leg_kick = leg_wr_cfg && (index_q == IDX_STATUS) &&
    i_io_wdata[BIT_KICK];

  wdog_tmr_if leg_if ();
  wdog_tmr_if sec_if ();

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      index_q <= '0;
      unlock_q <= 1'b0;
      leg_en_q <= LEGACY_EN_RESET;
      leg_act_q <= '0;
      leg_lo_q <= '0;
      leg_mid_q <= '0;
      leg_hi_q <= '0;
    end else begin
      if (wr_index) begin
        index_q <= i_io_wdata;
      end
      if (wr_data && index_q == IDX_LOCK) begin
        unlock_q <= (i_io_wdata == UNLOCK_KEY);
      end
      if (leg_wr_cfg) begin
        case (index_q)
          IDX_ENABLE: leg_en_q <= i_io_wdata & ENABLE_MASK;
          IDX_ACT: leg_act_q <= i_io_wdata & ACT_MASK;
          IDX_CNT_LO: leg_lo_q <= i_io_wdata;
          IDX_CNT_MID: leg_mid_q <= i_io_wdata;
          IDX_CNT_HI: leg_hi_q <= i_io_wdata;
          default: ;
        endcase
      end
    end
  end

  // fired flag: set on expiry, cleared in the cycle after enable goes low
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      leg_fired_q <= 1'b0;
    end else begin
      leg_fired_q <= leg_if.expire ||
        (leg_fired_q && leg_en_q[BIT_ENABLE]);
    end
  end

  assign leg_if.enable = leg_en_q[BIT_ENABLE];
  assign leg_if.restart = leg_kick;
  assign leg_if.tick = tick;
  assign leg_if.limit = {leg_hi_q, leg_mid_q, leg_lo_q};

  wdog_core u_legacy (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tmr(leg_if.core)
  );

  // =========================================================
  // second watchdog registers
  logic [7:0] sec_ctrl_q, sec_act_q, sec_lo_q, sec_mid_q, sec_hi_q;
  logic sec_fired_q;
  logic sec_clr;
  assign sec_clr = sec_wr_status && i_io_wdata[BIT_FIRED];
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sec_ctrl_q <= SEC_EN_RESET;
      sec_act_q <= '0;
      sec_lo_q <= '0;
      sec_mid_q <= '0;
      sec_hi_q <= '0;
      sec_fired_q <= 1'b0;
    end else begin
      if (sec_wr_ctrl) begin
        sec_ctrl_q <= i_io_wdata & ENABLE_MASK;
      end
      if (sec_wr_act) begin
        sec_act_q <= i_io_wdata & ACT_MASK;
      end
      if (sec_wr_lo) begin
        sec_lo_q <= i_io_wdata;
      end
      if (sec_wr_mid) begin
        sec_mid_q <= i_io_wdata;
      end
      if (sec_wr_hi) begin
        sec_hi_q <= i_io_wdata;
      end
      // set wins over the write-one clear
      sec_fired_q <= sec_if.expire || (sec_fired_q && !sec_clr);
    end
  end

  assign sec_if.enable = sec_ctrl_q[BIT_ENABLE];
  assign sec_if.restart = sec_wr_reload;
  assign sec_if.tick = tick;
  assign sec_if.limit = {sec_hi_q, sec_mid_q, sec_lo_q};

  wdog_core u_second (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .tmr(sec_if.core)
  );

  // =========================================================
  // actions: registered pulse, one cycle after the expiry cycle
  logic [17:0] leg_vec, sec_vec, act_d;
  logic [17:0] act_q;
  assign leg_vec = leg_if.expire ?
    act_decode(leg_act_q[ACT_LSB +: 4]) : 18'h00000;
  assign sec_vec = sec_if.expire ?
    act_decode(sec_act_q[ACT_LSB +: 4]) : 18'h00000;
  assign act_d = leg_vec | sec_vec;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      act_q <= '0;
    end else begin
      act_q <= act_d;
    end
  end
  assign o_irq = act_q[15:0];
  assign o_nmi = act_q[16];
  assign o_sys_reset = act_q[17];

  // =========================================================
  // read path
  logic [7:0] leg_rd, sec_rd, rdata_d;
  logic [7:0] rdata_q;
  logic hit_q;
  always_comb begin
    case (index_q)
      IDX_ENABLE: leg_rd = leg_en_q;
      IDX_ACT: leg_rd = leg_act_q;
      IDX_CNT_LO: leg_rd = leg_lo_q;
      IDX_CNT_MID: leg_rd = leg_mid_q;
      IDX_CNT_HI: leg_rd = leg_hi_q;
      IDX_STATUS: leg_rd = {leg_fired_q, 7'h00};
      IDX_LOCK: leg_rd = {7'h00, unlock_q};
      default: leg_rd = 8'h00;
    endcase
  end
  always_comb begin
    case (i_io_addr)
      PORT_SEC_CTRL: sec_rd = sec_ctrl_q;
      PORT_SEC_ACT: sec_rd = sec_act_q;
      PORT_SEC_CNT_LO: sec_rd = sec_lo_q;
      PORT_SEC_CNT_MID: sec_rd = sec_mid_q;
      PORT_SEC_CNT_HI: sec_rd = sec_hi_q;
      PORT_SEC_STATUS: sec_rd = {sec_fired_q, 7'h00};
      default: sec_rd = READ_UNDEF;
    endcase
  end
  assign rdata_d = rd_data ? leg_rd :
    (i_io_addr == PORT_INDEX) ? index_q : sec_rd;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= '0;
      hit_q <= 1'b0;
    end else begin
      hit_q <= i_io_rd && (rd_data || port_sec || i_io_addr == PORT_INDEX);
      if (i_io_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end
  assign o_io_rdata = rdata_q;
  assign o_io_hit = hit_q;
endmodule : dual_watchdog_timer

// ==== sim/dual_watchdog_timer_asserts.sv ====
/*
  port checker for dual_watchdog_timer, bound to its top module.
  assumes wdog_pkg compiled first.
*/
`timescale 1ns/1ps
module dwt_asserts (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  input wire logic o_io_hit,
  input wire logic [15:0] o_irq,
  input wire logic o_nmi,
  input wire logic o_sys_reset
);
  import wdog_pkg::*;
  // ==========================================================
  // decode
  wire sec_range = i_io_addr >= PORT_SEC_RELOAD &&
    i_io_addr <= PORT_SEC_STATUS;
  wire mapped = i_io_addr == PORT_INDEX || i_io_addr == PORT_DATA ||
    sec_range;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence rd_at(logic [15:0] a);
    i_io_rd && i_io_addr == a;
  endsequence
  // ==========================================================
  // checks
  index_hit_a: assert property (rd_at(PORT_INDEX) |=> o_io_hit)
    else $error("index read not acknowledged");
  unmapped_read_a: assert property (i_io_rd && !mapped |=>
    !o_io_hit && o_io_rdata == READ_UNDEF) else $error("unmapped read");
  reload_read_a: assert property (rd_at(PORT_SEC_RELOAD) |=>
    o_io_hit && o_io_rdata == READ_UNDEF) else $error("reload read");
  idle_hit_a: assert property (!i_io_rd |=> !o_io_hit)
    else $error("hit without read");
  rdata_hold_a: assert property (!i_io_rd |=> $stable(o_io_rdata))
    else $error("read data moved");
  irq_lines_a: assert property ((o_irq & 16'h2907) == 16'h0000)
    else $error("undefined irq line");
  nmi_pulse_a: assert property (o_nmi |=> !o_nmi)
    else $error("nmi longer than one cycle");
  sysrst_pulse_a: assert property (o_sys_reset |=> !o_sys_reset)
    else $error("reset pulse too long");
endmodule : dwt_asserts

bind dual_watchdog_timer dwt_asserts dwt_asserts_inst (.i_clk(i_clk),
  .i_rst(i_rst), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr),
  .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
  .o_io_hit(o_io_hit), .o_irq(o_irq), .o_nmi(o_nmi),
  .o_sys_reset(o_sys_reset));

// ==== sim/io_host.sv ====
/*
  host model issuing byte i/o port cycles.
  assumes the bench owns the clock.
*/
`timescale 1ns/1ps
module io_host (
  input wire logic i_clk,
  input wire logic [7:0] i_io_rdata,
  input wire logic i_io_hit,
  output logic [15:0] o_io_addr,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_io_wdata
);
  import wdog_pkg::*;
  initial begin
    o_io_addr = 16'h0000;
    o_io_wr = 1'b0;
    o_io_rd = 1'b0;
    o_io_wdata = 8'h00;
  end
  // ==========================================================
  // cycles; released lines show inverted values
  task automatic io_wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge i_clk);
    o_io_addr <= a;
    o_io_wdata <= v;
    o_io_wr <= 1'b1;
    @(posedge i_clk);
    o_io_wr <= 1'b0;
    o_io_addr <= ~a;
    o_io_wdata <= ~v;
  endtask : io_wr
  task automatic io_rd(input logic [15:0] a, output logic [7:0] v,
    output logic h);
    @(posedge i_clk);
    o_io_addr <= a;
    o_io_rd <= 1'b1;
    @(posedge i_clk);
    o_io_rd <= 1'b0;
    o_io_addr <= ~a;
    #1;
    v = i_io_rdata;
    h = i_io_hit;
  endtask : io_rd
  task automatic leg_wr(input logic [7:0] idx, input logic [7:0] v);
    io_wr(PORT_INDEX, {8'h00, idx});
    io_wr(PORT_DATA, v);
  endtask : leg_wr
  task automatic leg_rd(input logic [7:0] idx, output logic [7:0] v);
    logic h;
    io_wr(PORT_INDEX, {8'h00, idx});
    io_rd(PORT_DATA, v, h);
  endtask : leg_rd
  task automatic unlock(input logic on);
    leg_wr(IDX_LOCK, on ? UNLOCK_KEY : 8'h00);
  endtask : unlock
endmodule : io_host

// ==== sim/dual_watchdog_timer_bench.sv ====
/*
  self-checking bench for dual_watchdog_timer.
  assumes wdog_pkg, the host model and the checker are compiled first.
*/
`timescale 1ns/1ps
module dual_watchdog_timer_bench;
  import wdog_pkg::*;
  localparam byte IRQ_OF[16] = '{0, 3, 4, 5, 6, 7, 9, 10, 0, 12, 14, 15,
    16, 17, 0, 0};
  logic i_clk, i_rst, wr, rd, h, nmi, srst;
  logic [15:0] addr, irq;
  logic [7:0] wdata, rdata, d;
  // task-side copy of the hit flag; h itself is driven by the design
  logic hv;
  logic [17:0] seen;
  int n_mismatch, checks_done;
  dual_watchdog_timer dual_watchdog_timer_inst (.i_clk(i_clk),
    .i_rst(i_rst), .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd),
    .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_hit(h), .o_irq(irq),
    .o_nmi(nmi), .o_sys_reset(srst));
  io_host io_host_inst (.i_clk(i_clk), .i_io_rdata(rdata), .i_io_hit(h),
    .o_io_addr(addr), .o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wdata));
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) seen <= seen | {srst, nmi, irq};
  // ==========================================================
  // helpers
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk8
  task automatic chk18(input logic [17:0] g, input logic [17:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk18
  task automatic clr();
    #1;
    seen = '0;
  endtask : clr
  task automatic wait_fire(input logic [17:0] e);
    int k;
    k = 0;
    while (seen === 18'h0 && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    #2;
    chk18(seen, e);
    if (e !== 18'h0 && k == 4000) wrap_up();
  endtask : wait_fire
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================
  // scenarios
  task automatic t_reset();
    io_host_inst.leg_rd(IDX_ENABLE, d);
    chk8(d, LEGACY_EN_RESET);
    io_host_inst.io_rd(PORT_INDEX, d, hv);
    chk8(d, IDX_ENABLE);
    chk8({7'h0, hv}, 8'h01);
    io_host_inst.io_rd(PORT_SEC_CTRL, d, hv);
    chk8(d, SEC_EN_RESET);
    io_host_inst.io_rd(16'h0070, d, hv);
    chk8({7'h0, hv}, 8'h00);
    chk8(d, READ_UNDEF);
    io_host_inst.io_rd(PORT_SEC_RELOAD, d, hv);
    chk8(d, READ_UNDEF);
  endtask : t_reset
  task automatic t_legacy();
    io_host_inst.unlock(1'b1);
    io_host_inst.leg_wr(IDX_ENABLE, 8'h00);
    io_host_inst.leg_wr(IDX_CNT_HI, 8'h00);
    io_host_inst.leg_wr(IDX_CNT_MID, 8'h00);
    io_host_inst.leg_wr(IDX_CNT_LO, 8'h03);
    io_host_inst.leg_wr(IDX_ACT, {ACT_NMI, 4'h0});
    io_host_inst.leg_wr(IDX_ENABLE, ENABLE_MASK);
    clr();
    // kicks fall at most two ticks apart, short of the limit
    repeat (4) begin
      repeat (1900) @(posedge i_clk);
      io_host_inst.leg_wr(IDX_STATUS, 8'h40);
    end
    chk18(seen, 18'h0);
    wait_fire(18'h10000);
    io_host_inst.leg_wr(IDX_STATUS, 8'h00);
    io_host_inst.leg_rd(IDX_STATUS, d);
    chk8(d & 8'h80, 8'h80);
    io_host_inst.leg_wr(IDX_ENABLE, 8'h00);
    io_host_inst.leg_rd(IDX_STATUS, d);
    chk8(d & 8'h80, 8'h00);
    io_host_inst.unlock(1'b0);
  endtask : t_legacy
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      io_host_inst.io_wr(PORT_SEC_CTRL, 8'h00);
      io_host_inst.io_wr(PORT_SEC_CNT_HI, 8'h00);
      io_host_inst.io_wr(PORT_SEC_CNT_MID, 8'h00);
      io_host_inst.io_wr(PORT_SEC_CNT_LO, 8'h01);
      io_host_inst.io_wr(PORT_SEC_ACT, {c[3:0], 4'h0});
      io_host_inst.io_wr(PORT_SEC_STATUS, 8'h80);
      io_host_inst.io_wr(PORT_SEC_CTRL, ENABLE_MASK);
      clr();
      wait_fire(IRQ_OF[c] == 0 ? 18'h0 : 18'h1 << IRQ_OF[c]);
      io_host_inst.io_rd(PORT_SEC_STATUS, d, hv);
      chk8(d, 8'h80);
    end
  endtask : t_codes
  task automatic t_reload();
    io_host_inst.io_wr(PORT_SEC_CTRL, 8'h00);
    io_host_inst.io_wr(PORT_SEC_CNT_LO, 8'h03);
    io_host_inst.io_wr(PORT_SEC_ACT, {ACT_NMI, 4'h0});
    io_host_inst.io_wr(PORT_SEC_STATUS, 8'h80);
    io_host_inst.io_rd(PORT_SEC_STATUS, d, hv);
    chk8(d, 8'h00);
    io_host_inst.io_wr(PORT_SEC_CTRL, ENABLE_MASK);
    clr();
    for (int i = 0; i < 4; i++) begin
      repeat (1900) @(posedge i_clk);
      io_host_inst.io_wr(PORT_SEC_RELOAD, 8'(i * 85));
    end
    chk18(seen, 18'h0);
    wait_fire(18'h10000);
  endtask : t_reload
  initial begin
    i_rst = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    seen = '0;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_legacy();
    t_codes();
    t_reload();
    wrap_up();
  end
endmodule : dual_watchdog_timer_bench
